// file: strap_pkg.sv
// Package for the serial register-access link: field widths and timing constants.
// Assumes both ends run on one system clock of 250 MHz.
package strap_pkg;
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int HDR_W     = 16;
  localparam int CNT_W     = 5;
  localparam int DIR_BIT   = 15;
  localparam logic DIR_WR  = 1'b1;
  localparam logic DIR_RD  = 1'b0;
  localparam logic [7:0] UNUSED_RD = 8'h00;
  localparam int SYS_CLK_PERIOD_PS = 4000;
  localparam int SCLK_PERIOD_NS    = 400;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS * 1000) / (2 * SYS_CLK_PERIOD_PS);
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    STRAP_IDLE = 2'b00,
    STRAP_HDR  = 2'b01,
    STRAP_DATA = 2'b10
  } strap_phase_t;
  typedef enum logic [2:0] {
    STRAPH_IDLE  = 3'b000,
    STRAPH_SEL   = 3'b001,
    STRAPH_LOW   = 3'b010,
    STRAPH_HIGH  = 3'b011,
    STRAPH_DONE  = 3'b100
  } straph_state_t;
endpackage : strap_pkg

// file: strap_if.sv
// Four-wire serial link between controller and target.
// Assumes the bench resolves nothing: all wires are single-driver.
interface strap_if;
  logic sel_n;
  logic sclk;
  logic ctd;
  logic tcd;
  modport ctrl (output sel_n, output sclk, output ctd, input tcd);
  modport tgt  (input sel_n, input sclk, input ctd, output tcd);
endinterface : strap_if

// file: strap_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and asynchronous active-low reset.
module strap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("strap_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              empty = (wr_ptr == rd_ptr);
  wire              full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  wire              push  = i_in_valid && !full;
  wire              pop   = !empty && i_out_ready;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : strap_fifo

// file: strap_target.sv
// Target end of the serial register-access link.
// Assumes the link pins are asynchronous to i_sys_clk and are synchronised here;
// the register store outside answers reads combinationally on o_rd_addr.
//
// Overview of operation
// RULE1: Write begins with direction bit one.
// RULE2: Fifteen-bit address, then eight-bit data byte.
// RULE3: All fields shifted most significant bit first.
// RULE4: Extra write bytes go to incremented addresses.
// RULE5: Read begins with direction bit zero.
// RULE6: First read bit driven by next falling edge.
// RULE7: Controller samples read bits on rising edges.
// RULE8: Controller ends read by raising select.
// RULE9: Continued clocking streams incremented read bytes.
// RULE10: Capture on rising, change on falling edges.
// RULE11: Select rising aborts, clears counter and state.
// RULE12: Ignore clock and data while deselected.
// RULE13: Unused reads give zero; unused writes ignored.
// RULE14: Header of sixteen bits, direction first bit.
module strap_target
  import strap_pkg::*;
#(
  parameter int DEPTH = strap_pkg::FIFO_DEPTH
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_n,
  strap_if.tgt                          link,
  output logic                          o_wr_valid,
  input  wire logic                     i_wr_ready,
  output logic [strap_pkg::ADDR_W-1:0]  o_wr_addr,
  output logic [strap_pkg::DATA_W-1:0]  o_wr_data,
  output logic [strap_pkg::ADDR_W-1:0]  o_rd_addr,
  input  wire logic [strap_pkg::DATA_W-1:0] i_rd_data,
  input  wire logic                     i_rd_mapped,
  input  wire logic                     i_wr_mapped,
  output logic                          o_overrun
);
  import strap_pkg::*;
  localparam int FW = ADDR_W + DATA_W;
  initial begin
    if (DEPTH < 2) $error("strap_target: DEPTH too small");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sel_s;
  logic [1:0] clk_s;
  logic [1:0] dat_s;
  logic       clk_d;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_s <= 2'h3;
      clk_s <= 2'h3;
      dat_s <= 2'h0;
      clk_d <= 1'b1;
    end else begin
      sel_s <= {sel_s[0], link.sel_n};
      clk_s <= {clk_s[0], link.sclk};
      dat_s <= {dat_s[0], link.ctd};
      clk_d <= clk_s[1];
    end
  end
  wire selected = !sel_s[1];
  wire rise     = selected && clk_s[1] && !clk_d;   // RULE10 RULE12
  wire fall     = selected && !clk_s[1] && clk_d;   // RULE10 RULE12
  wire mosi     = dat_s[1];

  // ==========================================================
  // Shift engine
  strap_phase_t        phase;
  strap_phase_t        next_phase;
  logic [CNT_W-1:0]    next_cnt;
  logic [HDR_W-1:0]    hdr;
  logic [CNT_W-1:0]    cnt;
  logic                dir_wr;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wsh;
  logic [DATA_W-1:0]   rsh;
  logic                miso;
  logic                load_pend;
  logic                overrun;
  logic                fifo_ready;
  logic                fifo_valid;
  logic [FW-1:0]       fifo_out;

  // ==========================================================
  // Decoding
  function automatic logic [DATA_W-1:0] shift_byte(input logic [DATA_W-1:0] v, input logic b);
    shift_byte = {v[DATA_W-2:0], b};
  endfunction : shift_byte

  wire [HDR_W-1:0]  hdr_next  = {hdr[HDR_W-2:0], mosi};              // RULE3
  wire              in_hdr    = (phase == STRAP_HDR);
  wire              in_data   = (phase == STRAP_DATA);
  wire              hdr_done  = in_hdr && rise && (cnt == CNT_W'(HDR_W - 1));
  wire              byte_done = in_data && rise && (cnt == CNT_W'(DATA_W - 1));
  wire              hdr_is_rd = (hdr_next[DIR_BIT] == DIR_RD);        // RULE14
  wire [DATA_W-1:0] wbyte     = shift_byte(wsh, mosi);                // RULE3
  wire              push      = byte_done && dir_wr && i_wr_mapped;   // RULE13
  wire [DATA_W-1:0] rd_val    = i_rd_mapped ? i_rd_data : UNUSED_RD;  // RULE13
  wire              rd_shift  = in_data && fall && !dir_wr;           // RULE6

  assign o_rd_addr = addr;

  // ==========================================================
  // Frame phase and bit counter
  always_comb begin
    next_phase = phase;
    next_cnt   = cnt;
    case (phase)
      STRAP_IDLE: begin
        next_phase = STRAP_HDR;
        next_cnt   = '0;
      end
      STRAP_HDR: begin
        if (hdr_done) begin
          next_phase = STRAP_DATA;
          next_cnt   = '0;
        end else if (rise) begin
          next_cnt = cnt + 1'b1;
        end
      end
      STRAP_DATA: begin
        if (byte_done) begin
          next_cnt = '0;
        end else if (rise) begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_phase = STRAP_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= STRAP_IDLE;
      cnt   <= '0;
    end else if (!selected) begin
      phase <= STRAP_IDLE;                             // RULE11
      cnt   <= '0;                                     // RULE11
    end else begin
      phase <= next_phase;
      cnt   <= next_cnt;
    end
  end

  // ==========================================================
  // Header capture and address counter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hdr    <= '0;
      dir_wr <= 1'b0;
      addr   <= '0;
    end else begin
      if (in_hdr && rise) begin
        hdr <= hdr_next;
      end
      if (hdr_done) begin
        dir_wr <= !hdr_is_rd;                          // RULE14 RULE1 RULE5
        addr   <= hdr_next[ADDR_W-1:0];                // RULE2
      end else if (byte_done) begin
        addr   <= addr + 1'b1;                         // RULE4 RULE9
      end
    end
  end

  // ==========================================================
  // Write byte shifter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wsh <= '0;
    end else if (in_data && rise) begin
      wsh <= wbyte;
    end
  end

  // ==========================================================
  // Read fetch and serial output
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_pend <= 1'b0;
      rsh       <= '0;
      miso      <= 1'b0;
    end else if (!selected) begin
      load_pend <= 1'b0;
      miso      <= 1'b0;
    end else begin
      if (hdr_done) begin
        load_pend <= hdr_is_rd;                        // RULE6
      end else if (byte_done && !dir_wr) begin
        load_pend <= 1'b1;                             // RULE9
      end else if (in_data) begin
        load_pend <= 1'b0;
      end
      if (in_data && load_pend) begin
        rsh <= rd_val;                                 // RULE6
      end else if (rd_shift) begin
        rsh <= shift_byte(rsh, 1'b0);                  // RULE3
      end
      if (in_hdr && fall) begin
        miso <= hdr[HDR_W-1];                          // Previous frame's header mirrored back
      end else if (rd_shift) begin
        miso <= rsh[DATA_W-1];                         // RULE6 RULE3
      end
    end
  end

  // ==========================================================
  // Lost write bytes, held until reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun <= 1'b0;
    end else if (push && !fifo_ready) begin
      overrun <= 1'b1;
    end
  end
  assign link.tcd  = miso;
  assign o_overrun = overrun;

  // ==========================================================
  // Write buffer
  strap_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({addr, wbyte}),                  // RULE2 RULE4
    .o_out_valid (fifo_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (fifo_out)
  );
  assign o_wr_valid = fifo_valid;
  assign o_wr_addr  = fifo_out[FW-1:DATA_W];
  assign o_wr_data  = fifo_out[DATA_W-1:0];
endmodule : strap_target

// file: strap_ctrl.sv
// Controller end: runs one transaction per request, makes the serial clock by a divider.
// Assumes the target tcd pin is asynchronous and synchronises it.
module strap_ctrl
  import strap_pkg::*;
#(
  parameter int HALF = strap_pkg::SCLK_HALF_CYC
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst_n,
  strap_if.ctrl                             link,
  input  wire logic                         i_req_valid,
  output logic                              o_req_ready,
  input  wire logic                         i_req_write,
  input  wire logic [strap_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [strap_pkg::DATA_W-1:0] i_req_wdata,
  input  wire logic [7:0]                   i_req_nbytes,
  output logic                              o_rd_valid,
  output logic [strap_pkg::DATA_W-1:0]      o_rd_data,
  output logic                              o_done
);
  import strap_pkg::*;
  initial begin
    if (HALF < 6 || HALF > 65536) $error("strap_ctrl: HALF must lie in 6..65536");
  end
  straph_state_t     st;
  logic [15:0]       div;
  logic [HDR_W-1:0]  sh;
  logic [CNT_W-1:0]  cnt;
  logic [7:0]        left;
  logic              wr;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] rsh;
  logic [1:0]        tcd_s;
  logic              sel_n;
  logic              sclk;
  logic              ctd;
  wire tick = (div == 16'(HALF - 1));
  wire [DATA_W-1:0] rnext = {rsh[DATA_W-2:0], tcd_s[1]};
  assign o_req_ready = (st == STRAPH_IDLE);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st         <= STRAPH_IDLE;
      div        <= '0;
      sh         <= '0;
      cnt        <= '0;
      left       <= '0;
      wr         <= 1'b0;
      wdat       <= '0;
      rsh        <= '0;
      tcd_s      <= '0;
      sel_n      <= 1'b1;
      sclk       <= 1'b1;
      ctd        <= 1'b1;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
      o_done     <= 1'b0;
    end else begin
      tcd_s      <= {tcd_s[0], link.tcd};
      o_rd_valid <= 1'b0;
      o_done     <= 1'b0;
      div        <= tick ? '0 : div + 1'b1;
      case (st)
        STRAPH_IDLE: begin
          if (i_req_valid) begin
            sh    <= {i_req_write ? DIR_WR : DIR_RD, i_req_addr}; // RULE1 RULE5 RULE14
            wr    <= i_req_write;
            wdat  <= i_req_wdata;
            left  <= (i_req_nbytes == 8'h00) ? 8'h01 : i_req_nbytes;
            cnt   <= CNT_W'(HDR_W + DATA_W - 1);
            sel_n <= 1'b0;
            div   <= '0;
            st    <= STRAPH_SEL;
          end
        end
        STRAPH_SEL: if (tick) begin
          st <= STRAPH_LOW;
        end
        STRAPH_LOW: if (tick) begin
          sclk <= 1'b0;                             // RULE10
          ctd  <= (cnt < CNT_W'(DATA_W)) ? wdat[DATA_W-1] : sh[HDR_W-1]; // RULE3 RULE2
          st   <= STRAPH_HIGH;
        end
        STRAPH_HIGH: if (tick) begin
          sclk <= 1'b1;
          sh   <= {sh[HDR_W-2:0], 1'b0};
          if (cnt < CNT_W'(DATA_W)) begin
            wdat <= {wdat[DATA_W-2:0], 1'b0};
            rsh  <= rnext;                          // RULE7
          end
          if (cnt == '0) begin
            o_rd_valid <= !wr;
            o_rd_data  <= rnext;
            if (left == 8'h01) begin
              st <= STRAPH_DONE;                    // RULE8
            end else begin
              left <= left - 1'b1;
              cnt  <= CNT_W'(DATA_W - 1);           // RULE4 RULE9
              wdat <= i_req_wdata;
              st   <= STRAPH_LOW;
            end
          end else begin
            cnt <= cnt - 1'b1;
            st  <= STRAPH_LOW;
          end
        end
        STRAPH_DONE: if (tick) begin
          sel_n  <= 1'b1;                           // RULE8 RULE11
          o_done <= 1'b1;
          st     <= STRAPH_IDLE;
        end
        default: st <= STRAPH_IDLE;
      endcase
    end
  end
  assign link.sel_n = sel_n;
  assign link.sclk  = sclk;
  assign link.ctd   = ctd;
endmodule : strap_ctrl

// file: strap_properties.sv
// Checker on the four link wires between controller and target.
// Assumes the controller is built with a half period of 6 system cycles.
module strap_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic ctd,
  input wire logic tcd
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // Rising serial clock edges in the current frame
  logic [7:0] rises;
  logic       sclk_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rises  <= 8'h00;
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      rises  <= sel_n ? 8'h00 : rises + 8'(sclk & ~sclk_q);
    end
  end
  // ==========================================
  // Properties
  AST_SCLK_IDLE: assert property (sel_n |-> sclk) else $error("sclk low while deselected");
  AST_SEL_START: assert property ($fell(sel_n) |-> sclk ##[1:12] $fell(sclk))
    else $error("no first clock fall after select");
  AST_CTD_HOLD: assert property ($rose(sclk) |-> $stable(ctd)) else $error("ctd moved at rise");
  AST_LOW_HALF: assert property ($fell(sclk) |-> !sclk [*6] ##1 sclk) else $error("bad low phase");
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*6]) else $error("bad high phase");
  AST_TCD_LOW: assert property ((!sel_n) [*6] ##0 !$stable(tcd) |-> !sclk)
    else $error("tcd moved while sclk high");
  AST_FRAME_LEN: assert property ($rose(sel_n) |-> rises[2:0] == 3'h0 && rises >= 8'd24)
    else $error("frame not header plus whole bytes");
  AST_END_HIGH: assert property ($rose(sel_n) |-> sclk && $past(sclk))
    else $error("select raised with sclk low");
endmodule : strap_properties

// file: spi_target_register_access_tb.sv
// Bench: controller and target back to back, second target driven by hand.
// Assumes 256 mapped bytes below address 15'h0100.
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spi_target_register_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import strap_pkg::*;
  logic              i_sys_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic              rv = 0, rw = 0, wr_ready = 0, stall = 0;
  logic [ADDR_W-1:0] ra = '0;
  logic [DATA_W-1:0] rd = '0;
  logic [7:0]        rn = 8'h01;
  logic              done, rd_valid, wr_valid, overrun, wr_valid2;
  logic [ADDR_W-1:0] wr_addr, rd_addr, wr_addr2;
  logic [DATA_W-1:0] rd_data, wr_data, wr_data2;
  logic [7:0]        mem [256];
  logic [7:0]        ref_mem [256];
  logic [23:0]       ctd_sh;
  logic [7:0]        tcd_sh;
  logic [15:0]       hdr_sh;
  int                nrise = 0;
  logic [7:0]        rdq [$];
  int                error_cnt = 0;
  int                checks = 0;
  strap_if lnk();
  strap_if lnk2();
  always #2 i_sys_clk = ~i_sys_clk;
  // ==========================================
  // Design, checker and register store
  strap_ctrl #(.HALF(6)) strap_ctrl_i (.i_sys_clk, .i_rst_n, .link(lnk), .i_req_valid(rv), .o_req_ready(),
    .i_req_write(rw), .i_req_addr(ra), .i_req_wdata(rd), .i_req_nbytes(rn), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_done(done));
  strap_target strap_target_i (.i_sys_clk, .i_rst_n, .link(lnk), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr), .i_rd_data(mem[rd_addr[7:0]]),
    .i_rd_mapped(rd_addr[14:8] == 7'h00), .i_wr_mapped(rd_addr[14:8] == 7'h00), .o_overrun(overrun));
  strap_target strap_target_i2 (.i_sys_clk, .i_rst_n, .link(lnk2), .o_wr_valid(wr_valid2), .i_wr_ready(1'b0),
    .o_wr_addr(wr_addr2), .o_wr_data(wr_data2), .o_rd_addr(), .i_rd_data(8'h00), .i_rd_mapped(1'b1),
    .i_wr_mapped(1'b1), .o_overrun());
  strap_properties strap_properties_i (.i_sys_clk, .i_rst_n, .sel_n(lnk.sel_n), .sclk(lnk.sclk),
    .ctd(lnk.ctd), .tcd(lnk.tcd));
  always @(negedge i_sys_clk) wr_ready <= !stall && $urandom_range(0, 1);
  always @(posedge i_sys_clk) if (wr_valid && wr_ready) mem[wr_addr[7:0]] <= wr_data;
  always @(posedge i_sys_clk) if (rd_valid) rdq.push_back(rd_data);
  always @(posedge lnk.sclk) if (!lnk.sel_n) begin
    ctd_sh <= {ctd_sh[22:0], lnk.ctd};
    tcd_sh <= {tcd_sh[6:0], lnk.tcd};
    if (nrise < HDR_W) hdr_sh <= {hdr_sh[14:0], lnk.ctd};
    nrise <= nrise + 1;
  end
  // ==========================================
  // Tasks
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d, input logic [7:0] n);
    int k;
    logic [14:0] ak;
    rdq.delete();
    nrise = 0;
    @(negedge i_sys_clk);
    {rv, rw, ra, rd, rn} = {1'b1, w, a, d, n};
    @(negedge i_sys_clk);
    rv = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(negedge i_sys_clk);
      k++;
    end
    `CMP(done, 1'b1)
    for (k = 0; k < (n == 0 ? 1 : n); k++) begin
      ak = a + 15'(k);
      if (w && ak[14:8] == 7'h00) ref_mem[ak[7:0]] = d;
      if (!w) `CMP(rdq[k], ak[14:8] == 7'h00 ? ref_mem[ak[7:0]] : UNUSED_RD)
    end
    if (!w) `CMP(rdq.size(), (n == 0 ? 1 : int'(n)))
    if (w && n == 1) `CMP(ctd_sh, {1'b1, a, d})
    if (!w && n == 1) `CMP(tcd_sh, rdq[0])
    `CMP(hdr_sh, {w, a})
    `CMP(nrise, HDR_W + DATA_W * (n == 0 ? 1 : int'(n)))
    repeat (40) @(negedge i_sys_clk);
  endtask : xfer
  task automatic bang(input int nb, input logic [23:0] v);
    lnk2.sel_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      repeat (8) @(negedge i_sys_clk);
      {lnk2.sclk, lnk2.ctd} = {1'b0, v[i]};
      repeat (8) @(negedge i_sys_clk);
      lnk2.sclk = 1'b1;
    end
    repeat (6) @(negedge i_sys_clk);
    {lnk2.sel_n, lnk2.ctd} = {1'b1, ~lnk2.ctd};
    repeat (10) @(negedge i_sys_clk);
  endtask : bang
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Sequence
  initial begin
    #380000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [7:0] keep [2];
    {lnk2.sel_n, lnk2.sclk, lnk2.ctd} = 3'b111;
    void'($urandom(32'h213b162b));
    for (int i = 0; i < 256; i++) {mem[i], ref_mem[i]} = {8'(i), 8'(i)};
    repeat (10) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    xfer(1, 15'h0010, 8'ha5, 1);
    xfer(0, 15'h0010, 8'h00, 1);
    xfer(1, 15'h7fff, 8'h3c, 2);
    xfer(0, 15'h7ffe, 8'h00, 3);
    xfer(0, 15'h0020, 8'h00, 0);
    xfer(1, 15'h00fe, 8'h77, 3);
    for (int i = 0; i < 24; i++) xfer(1'($urandom), 15'($urandom_range(0, 383)), 8'($urandom), 8'($urandom_range(0, 3)));
    `CMP(overrun, 1'b0)
    keep = '{ref_mem[8'h48], ref_mem[8'h49]};
    stall = 1'b1;
    xfer(1, 15'h0040, 8'h99, 10);
    `CMP(overrun, 1'b1)
    `CMP(wr_valid, 1'b1)
    stall = 1'b0;
    {ref_mem[8'h48], ref_mem[8'h49]} = {keep[0], keep[1]};
    repeat (60) @(negedge i_sys_clk);
    `CMP(wr_valid, 1'b0)
    xfer(0, 15'h0040, 8'h00, 10);
    bang(20, 24'h80125a >> 4);
    `CMP(wr_valid2, 1'b0)
    repeat (40) begin
      @(negedge i_sys_clk);
      {lnk2.sclk, lnk2.ctd} = 2'($urandom);
    end
    lnk2.sclk = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    `CMP(wr_valid2, 1'b0)
    bang(24, 24'h80125a);
    `CMP(wr_valid2, 1'b1)
    `CMP(wr_addr2, 15'h0012)
    `CMP(wr_data2, 8'h5a)
    report_and_stop();
  end
endmodule : spi_target_register_access_tb
